// file: rtl/update_cfg.svh
// Addresses, reset values and timing counts for the remote register update pair.
// Assumes a 10 MHz ref_clk; included by its bare name from the two ends and the testbench.
`ifndef UPDATE_CFG_SVH
`define UPDATE_CFG_SVH

// Update flag registers
`define FMT_FLAG_ADDR   8'h1B
`define LNK_FLAG_ADDR   8'h3E
`define RCV_FLAG_ADDR   8'h4B

// Guarded format group: audio format, latency, serial input config, serial rate
`define FMT_BASE_ADDR   8'h10
`define FMT_LAST_IDX    2'h3
// Guarded link control group
`define LNK_BASE_ADDR   8'h30
`define LNK_LAST_IDX    2'h1
// Guarded receiver control group
`define RCV_BASE_ADDR   8'h40
`define RCV_LAST_IDX    2'h1

`define REG_RESET       8'h00
`define FLAG_RESET      1'b0
`define RD_UNMAPPED     8'h00
`define IDX_FIRST       2'h0
`define IDX_STEP        2'h1
`define TIMER_ZERO      8'h00
`define TIMER_STEP      8'h01

// Timing, in ns, and derived cycle counts
`define CLK_PERIOD_NS   100
`define ACK_WAIT_NS     1600
`define RELINK_TIME_NS  2000
// Longest wait rounds down
`define ACK_CYCLES      (`ACK_WAIT_NS / `CLK_PERIOD_NS)
// Least link-down time rounds up
`define RELINK_CYCLES   ((`RELINK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: rtl/update_pkg.sv
// Types shared by both ends of the register update link.
// Enum codes are set here as literals; it does not include update_cfg.svh.
package update_pkg;
   typedef enum logic [1:0] {
      GRP_FMT = 2'b00,
      GRP_LNK = 2'b01,
      GRP_RCV = 2'b10
   } group_e;

   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_SEND     = 2'b01,
      ST_WAIT_ACK = 2'b10,
      ST_RELINK   = 2'b11
   } state_e;
endpackage : update_pkg

// file: rtl/update_link_if.sv
// Data link between the transmitting end and the receiving end.
// Assumes both ends run on the same ref_clk; the testbench joins them.
`timescale 1ns/100ps
interface update_link_if;
   import update_pkg::*;
   logic       frameValid;   // Word on the link this cycle
   group_e     frameGroup;   // Which register group the word belongs to
   logic [1:0] frameIndex;   // Register index inside the group
   logic [7:0] frameData;
   logic       frameLast;    // Final word of the group
   logic       ackValid;     // One-cycle answer to a complete group
   logic       ackOk;        // High when the receiver took the group
   logic       linkUp;       // Link established, driven by the transmitter

   modport tx_end (
      output frameValid, frameGroup, frameIndex, frameData, frameLast, linkUp,
      input  ackValid, ackOk
   );
   modport rx_end (
      input  frameValid, frameGroup, frameIndex, frameData, frameLast, linkUp,
      output ackValid, ackOk
   );
endinterface : update_link_if

// file: rtl/update_tx_end.sv
// Transmitting end: update flags, guarded register groups and the group sender.
// Assumes a local microcontroller port on ref_clk and the receiver across link.
`timescale 1ns/100ps
`include "update_cfg.svh"

// Function
// [R1] Receiver microcontroller never writes the flags
// [R2] Format flag set sends four format registers
// [R3] Format success clears flag, then relinks
// [R4] Format group locked while its flag reads one
// [R5] Microcontroller polls flag before touching group
// [R6] Link flag sends link group, clears, relinks
// [R7] Link group locked while link flag set
// [R8] Receiver flag sends receiver group, clears flag
// [R9] Receiver group locked while its flag set
// [R10] Flag stays set until confirmed success
module update_tx_end
   import update_pkg::*;
(
   input  wire logic            ref_clk,
   input  wire logic            rst,
   input  wire logic            regWrite,
   input  wire logic            regRead,
   input  wire logic [7:0]      regAddr,
   input  wire logic [7:0]      regWdata,
   output logic      [7:0]      regRdata,
   output logic                 regRdValid,
   output logic                 updateBusy,
   update_link_if.tx_end        link
);
   logic            fmtFlag,    next_fmtFlag;
   logic            lnkFlag,    next_lnkFlag;
   logic            rcvFlag,    next_rcvFlag;
   logic [3:0][7:0] fmtRegs,    next_fmtRegs;
   logic [1:0][7:0] lnkRegs,    next_lnkRegs;
   logic [1:0][7:0] rcvRegs,    next_rcvRegs;
   logic [7:0]      next_regRdata;
   logic            next_regRdValid;

   state_e          state,      next_state;
   group_e          group,      next_group;
   logic [7:0]      timer,      next_timer;
   logic            linkUp,     next_linkUp;
   logic            fValid,     next_fValid;
   logic [1:0]      fIndex,     next_fIndex;
   logic [7:0]      fData,      next_fData;
   logic            fLast,      next_fLast;
   logic            clearFmt;
   logic            clearLnk;
   logic            clearRcv;
   logic [1:0]      idx;
   logic [1:0]      lastIdx;
   group_e          pickGroup;

   // Word of the active group at a given index
   function automatic logic [7:0] wordAt(input group_e g, input logic [1:0] i,
                                         input logic [3:0][7:0] f,
                                         input logic [1:0][7:0] l,
                                         input logic [1:0][7:0] r);
      case (g)
         GRP_FMT: wordAt = f[i];
         GRP_LNK: wordAt = l[i[0]];
         GRP_RCV: wordAt = r[i[0]];
         default: wordAt = `REG_RESET;
      endcase
   endfunction : wordAt

   // Register file: flags, guarded groups and read port
   always_comb begin
      next_fmtFlag = clearFmt ? 1'b0 : fmtFlag;
      next_lnkFlag = clearLnk ? 1'b0 : lnkFlag;
      next_rcvFlag = clearRcv ? 1'b0 : rcvFlag;
      next_fmtRegs = fmtRegs;
      next_lnkRegs = lnkRegs;
      next_rcvRegs = rcvRegs;
      // Software write beats the hardware clear, so a new request is never lost
      if (regWrite) begin
         if (regAddr == `FMT_FLAG_ADDR) begin
            next_fmtFlag = regWdata[0];                                 // [R2]
         end
         if (regAddr == `LNK_FLAG_ADDR) begin
            next_lnkFlag = regWdata[0];                                 // [R6]
         end
         if (regAddr == `RCV_FLAG_ADDR) begin
            next_rcvFlag = regWdata[0];                                 // [R8]
         end
         // Locked groups drop writes so the words in flight stay coherent
         for (int i = 0; i <= 3; i++) begin
            if (!fmtFlag && regAddr == `FMT_BASE_ADDR + 8'(i)) begin    // [R4]
               next_fmtRegs[i] = regWdata;
            end
         end
         for (int i = 0; i <= 1; i++) begin
            if (!lnkFlag && regAddr == `LNK_BASE_ADDR + 8'(i)) begin    // [R7]
               next_lnkRegs[i] = regWdata;
            end
            if (!rcvFlag && regAddr == `RCV_BASE_ADDR + 8'(i)) begin    // [R9]
               next_rcvRegs[i] = regWdata;
            end
         end
      end
      // Flags read back bit 0 only; upper bits read zero
      next_regRdValid = regRead;
      next_regRdata   = `RD_UNMAPPED;
      if (regRead) begin
         if (regAddr == `FMT_FLAG_ADDR) next_regRdata = {7'h00, fmtFlag};  // [R5]
         if (regAddr == `LNK_FLAG_ADDR) next_regRdata = {7'h00, lnkFlag};
         if (regAddr == `RCV_FLAG_ADDR) next_regRdata = {7'h00, rcvFlag};
         for (int i = 0; i <= 3; i++) begin
            if (regAddr == `FMT_BASE_ADDR + 8'(i)) next_regRdata = fmtRegs[i];
         end
         for (int i = 0; i <= 1; i++) begin
            if (regAddr == `LNK_BASE_ADDR + 8'(i)) next_regRdata = lnkRegs[i];
            if (regAddr == `RCV_BASE_ADDR + 8'(i)) next_regRdata = rcvRegs[i];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fmtFlag    <= `FLAG_RESET;
         lnkFlag    <= `FLAG_RESET;
         rcvFlag    <= `FLAG_RESET;
         fmtRegs    <= '0;
         lnkRegs    <= '0;
         rcvRegs    <= '0;
         regRdata   <= `REG_RESET;
         regRdValid <= 1'b0;
      end else begin
         fmtFlag    <= next_fmtFlag;
         lnkFlag    <= next_lnkFlag;
         rcvFlag    <= next_rcvFlag;
         fmtRegs    <= next_fmtRegs;
         lnkRegs    <= next_lnkRegs;
         rcvRegs    <= next_rcvRegs;
         regRdata   <= next_regRdata;
         regRdValid <= next_regRdValid;
      end
   end

   // Fixed priority: format, then link, then receiver group
   assign pickGroup = fmtFlag ? GRP_FMT : (lnkFlag ? GRP_LNK : GRP_RCV);
   assign lastIdx   = (group == GRP_FMT) ? `FMT_LAST_IDX :
                      ((group == GRP_LNK) ? `LNK_LAST_IDX : `RCV_LAST_IDX);
   assign idx       = fIndex + `IDX_STEP;

   // Sender: stream the group, await the answer, relink when required
   always_comb begin
      next_state  = state;
      next_group  = group;
      next_timer  = timer;
      next_linkUp = linkUp;
      next_fValid = 1'b0;
      next_fIndex = fIndex;
      next_fData  = fData;
      next_fLast  = 1'b0;
      clearFmt    = 1'b0;
      clearLnk    = 1'b0;
      clearRcv    = 1'b0;
      case (state)
         ST_IDLE: begin
            if (linkUp && (fmtFlag || lnkFlag || rcvFlag)) begin      // [R2] [R6] [R8]
               next_group  = pickGroup;
               next_fValid = 1'b1;
               next_fIndex = `IDX_FIRST;
               next_fData  = wordAt(pickGroup, `IDX_FIRST, fmtRegs, lnkRegs, rcvRegs);
               next_state  = ST_SEND;
            end
         end
         ST_SEND: begin
            if (fLast) begin
               next_timer = `TIMER_ZERO;
               next_state = ST_WAIT_ACK;
            end else begin
               next_fValid = 1'b1;
               next_fIndex = idx;
               next_fData  = wordAt(group, idx, fmtRegs, lnkRegs, rcvRegs);
               next_fLast  = (idx == lastIdx);
            end
            // Single-word groups never exist, so the first word is never last
         end
         ST_WAIT_ACK: begin
            next_timer = timer + `TIMER_STEP;
            if (link.ackValid && link.ackOk) begin
               clearFmt = (group == GRP_FMT);                           // [R3]
               clearLnk = (group == GRP_LNK);                           // [R6]
               clearRcv = (group == GRP_RCV);                           // [R8]
               next_timer = `TIMER_ZERO;
               if (group == GRP_RCV) begin
                  next_state = ST_IDLE;
               end else begin
                  next_linkUp = 1'b0;                                   // [R3] [R6]
                  next_state  = ST_RELINK;
               end
            end else if (link.ackValid || timer == 8'(`ACK_CYCLES)) begin
               next_state = ST_IDLE;                                    // [R10]
            end
         end
         ST_RELINK: begin
            next_timer = timer + `TIMER_STEP;
            if (timer == 8'(`RELINK_CYCLES - 1)) begin
               next_linkUp = 1'b1;
               next_state  = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state  <= ST_IDLE;
         group  <= GRP_FMT;
         timer  <= `TIMER_ZERO;
         linkUp <= 1'b1;
         fValid <= 1'b0;
         fIndex <= `IDX_FIRST;
         fData  <= `REG_RESET;
         fLast  <= 1'b0;
      end else begin
         state  <= next_state;
         group  <= next_group;
         timer  <= next_timer;
         linkUp <= next_linkUp;
         fValid <= next_fValid;
         fIndex <= next_fIndex;
         fData  <= next_fData;
         fLast  <= next_fLast;
      end
   end

   assign link.frameValid = fValid;
   assign link.frameGroup = group;
   assign link.frameIndex = fIndex;
   assign link.frameData  = fData;
   assign link.frameLast  = fLast;
   assign link.linkUp     = linkUp;
   assign updateBusy      = (state != ST_IDLE);
endmodule : update_tx_end

// file: rtl/update_rx_end.sv
// Receiving end: collects group words and commits them on a clean last word.
// Assumes the transmitting end on the same ref_clk drives the link.
`timescale 1ns/100ps
`include "update_cfg.svh"

module update_rx_end
   import update_pkg::*;
(
   input  wire logic            ref_clk,
   input  wire logic            rst,
   input  wire logic            refuseUpdate,
   output logic [3:0][7:0]      formatRegs,
   output logic [1:0][7:0]      linkRegs,
   output logic [1:0][7:0]      receiverRegs,
   output logic                 updateDone,
   output group_e               updateGroup,
   output logic                 linkActive,
   update_link_if.rx_end        link
);
   logic [3:0][7:0] stage,       next_stage;
   logic [3:0][7:0] next_formatRegs;
   logic [1:0][7:0] next_linkRegs;
   logic [1:0][7:0] next_receiverRegs;
   logic            next_updateDone;
   group_e          next_updateGroup;
   logic            ackValid,    next_ackValid;
   logic            ackOk,       next_ackOk;
   logic            commit;

   // Collect words; a refused group leaves the copies untouched.
   // This end has no path to the update flags at all.              [R1]
   always_comb begin
      next_stage        = stage;
      next_formatRegs   = formatRegs;
      next_linkRegs     = linkRegs;
      next_receiverRegs = receiverRegs;
      next_updateGroup  = updateGroup;
      next_ackValid     = 1'b0;
      next_ackOk        = 1'b0;
      commit            = 1'b0;
      if (link.frameValid) begin
         next_stage[link.frameIndex] = link.frameData;
         if (link.frameLast) begin
            next_ackValid    = 1'b1;
            next_ackOk       = !refuseUpdate;                         // [R10]
            commit           = !refuseUpdate;
            next_updateGroup = link.frameGroup;
         end
      end
      if (commit) begin
         case (link.frameGroup)
            GRP_FMT: next_formatRegs   = next_stage;                  // [R2]
            GRP_LNK: next_linkRegs     = next_stage[1:0];             // [R6]
            GRP_RCV: next_receiverRegs = next_stage[1:0];             // [R8]
            default: next_formatRegs   = formatRegs;
         endcase
      end
      next_updateDone = commit;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage        <= '0;
         formatRegs   <= '0;
         linkRegs     <= '0;
         receiverRegs <= '0;
         updateDone   <= 1'b0;
         updateGroup  <= GRP_FMT;
         ackValid     <= 1'b0;
         ackOk        <= 1'b0;
      end else begin
         stage        <= next_stage;
         formatRegs   <= next_formatRegs;
         linkRegs     <= next_linkRegs;
         receiverRegs <= next_receiverRegs;
         updateDone   <= next_updateDone;
         updateGroup  <= next_updateGroup;
         ackValid     <= next_ackValid;
         ackOk        <= next_ackOk;
      end
   end

   assign link.ackValid = ackValid;
   assign link.ackOk    = ackOk;
   assign linkActive    = link.linkUp;
endmodule : update_rx_end

// file: bench/remote_register_update_ctrl_props.sv
// Checker for the link between the transmitting and the receiving end.
// Assumes the testbench feeds it the interface signals, all on ref_clk.
`timescale 1ns/100ps
module remote_register_update_ctrl_props
   import update_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       frameValid,
   input group_e          frameGroup,
   input wire logic [1:0] frameIndex,
   input wire logic       frameLast,
   input wire logic       ackValid,
   input wire logic       ackOk,
   input wire logic       linkUp
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Group shapes: a short group would leave the receiver half updated
   AST_FMT_WORDS: assert property (
      frameValid && frameGroup == GRP_FMT && frameIndex == 2'h0 |-> !frameLast
      ##1 frameValid && frameIndex == 2'h1 ##1 frameValid && frameIndex == 2'h2
      ##1 frameValid && frameIndex == 2'h3 && frameLast)
      else $error("format group is not four words");
   AST_LNK_WORDS: assert property (
      frameValid && frameGroup == GRP_LNK && frameIndex == 2'h0 |-> !frameLast
      ##1 frameValid && frameGroup == GRP_LNK && frameIndex == 2'h1 && frameLast)
      else $error("link group is not two words");
   AST_RCV_WORDS: assert property (
      frameValid && frameGroup == GRP_RCV && frameIndex == 2'h0 |-> !frameLast
      ##1 frameValid && frameGroup == GRP_RCV && frameIndex == 2'h1 && frameLast)
      else $error("receiver group is not two words");
   // Every complete group gets exactly one answer
   AST_ACK_FOLLOWS: assert property (frameValid && frameLast |=> ackValid)
      else $error("no answer after last word");
   AST_ACK_CAUSE: assert property (ackValid |-> $past(frameValid) && $past(frameLast))
      else $error("answer without a last word");
   // Relink only after a good format or link group
   AST_RELINK_START: assert property (
      ackValid && ackOk && $past(frameGroup) != GRP_RCV |=> !linkUp)
      else $error("link not dropped after good group");
   AST_RELINK_LEN: assert property ($fell(linkUp) |-> ##19 !linkUp ##1 linkUp)
      else $error("link down time not twenty cycles");
   AST_RCV_NO_RELINK: assert property (
      ackValid && ackOk && $past(frameGroup) == GRP_RCV |=> linkUp [*2])
      else $error("link dropped after receiver group");
   // A refused group keeps the link and is sent again
   AST_NACK_RETRY: assert property (
      ackValid && !ackOk |=> linkUp ##[1:6] frameValid && frameIndex == 2'h0)
      else $error("refused group not retried");
   AST_QUIET_DOWN: assert property (!linkUp |-> !frameValid)
      else $error("word sent while link down");

   COV_FMT_OK: cover property (ackValid && ackOk && $past(frameGroup) == GRP_FMT);
   COV_NACK: cover property (ackValid && !ackOk);
   COV_RELINK: cover property ($rose(linkUp));
endmodule : remote_register_update_ctrl_props

// file: bench/test_remote_register_update_ctrl.sv
// Testbench: both ends joined by the link interface, driven from the register port.
// Assumes update_pkg types and the addresses of update_cfg.svh.
`timescale 1ns/100ps
`include "update_cfg.svh"
module test_remote_register_update_ctrl;
   import update_pkg::*;
   logic            ref_clk = 1'b0;
   logic            rst = 1'b1;
   logic            regWrite = 1'b0;
   logic            regRead = 1'b0;
   logic [7:0]      regAddr = 8'h00;
   logic [7:0]      regWdata = 8'h00;
   logic            refuseUpdate = 1'b0;
   logic [7:0]      regRdata;
   logic            regRdValid;
   logic            updateBusy;
   logic [3:0][7:0] formatRegs;
   logic [1:0][7:0] linkRegs;
   logic [1:0][7:0] receiverRegs;
   logic            updateDone;
   group_e          updateGroup;
   logic            linkActive;
   int              err_count = 0;
   int              total_checks = 0;
   int              doneCount = 0;

   // Free running clock, 100 ns period
   always #50 ref_clk = ~ref_clk;

   // Counts committed groups at the receiver; refused groups must not pulse
   always @(posedge ref_clk) begin
      if (updateDone === 1'b1) doneCount <= doneCount + 1;
   end

   update_link_if link ();
   update_tx_end u_update_tx_end (.ref_clk(ref_clk), .rst(rst), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .regRdValid(regRdValid), .updateBusy(updateBusy), .link(link));
   // Receiver end has no register port: its side never writes the flags
   update_rx_end u_update_rx_end (.ref_clk(ref_clk), .rst(rst), .refuseUpdate(refuseUpdate),
      .formatRegs(formatRegs), .linkRegs(linkRegs), .receiverRegs(receiverRegs),
      .updateDone(updateDone), .updateGroup(updateGroup), .linkActive(linkActive),
      .link(link));
   remote_register_update_ctrl_props u_remote_register_update_ctrl_props (
      .ref_clk(ref_clk), .rst(rst), .frameValid(link.frameValid),
      .frameGroup(link.frameGroup), .frameIndex(link.frameIndex),
      .frameLast(link.frameLast), .ackValid(link.ackValid), .ackOk(link.ackOk),
      .linkUp(link.linkUp));

   // Counts one comparison, reports a mismatch at once
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask : wr

   // Read data only counts when the valid pulse is there
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 v = regRdValid ? regRdata : 8'hXX;
   endtask : rd

   // Bounded poll; a flag that never clears ends the run
   task automatic wait_clear(input logic [7:0] a);
      logic [7:0] v;
      for (int i = 0; i < 100; i++) begin
         rd(a, v);
         if (v === 8'h00) return;
      end
      check(v, 8'h00);
      conclude();
   endtask : wait_clear

   function automatic logic [7:0] received(input group_e g, input int i);
      case (g)
         GRP_FMT: return formatRegs[i[1:0]];
         GRP_LNK: return linkRegs[i[0]];
         default: return receiverRegs[i[0]];
      endcase
   endfunction : received

   // One group update; optionally the receiver refuses it for a while first
   task automatic run_group(input group_e g, input logic [7:0] flag, input logic [7:0] base,
                            input int n, input bit refuse);
      logic [7:0] v;
      int         doneBefore;
      doneBefore = doneCount;
      for (int i = 0; i < n; i++) wr(base + i[7:0], 8'hA0 + i[7:0]);
      refuseUpdate <= refuse;
      wr(flag, 8'h01);
      wr(base, 8'h5A);
      // Sender is mid-group here even when retries pass through idle
      #1 check({7'h00, updateBusy}, 8'h01);
      rd(flag, v);
      check(v, 8'h01);
      if (refuse) begin
         repeat (80) @(posedge ref_clk);
         rd(flag, v);
         check(v, 8'h01);
         check(received(g, 0), 8'h00);
         @(posedge ref_clk);
         refuseUpdate <= 1'b0;
      end
      wait_clear(flag);
      check(8'(doneCount - doneBefore), 8'h01);
      check({7'h00, linkActive}, {7'h00, g == GRP_RCV});
      for (int i = 0; i < 40 && linkActive !== 1'b1; i++) @(posedge ref_clk);
      check({7'h00, linkActive}, 8'h01);
      if (linkActive !== 1'b1) conclude();
      check({6'h00, updateGroup}, {6'h00, g});
      for (int i = 0; i < n; i++) begin
         rd(base + i[7:0], v);
         check(v, 8'hA0 + i[7:0]);
         check(received(g, i), 8'hA0 + i[7:0]);
      end
   endtask : run_group

   task automatic conclude();
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   // Main sequence: reset values, unmapped place, then each group in turn
   initial begin
      logic [7:0] v;
      logic [7:0] addrs [7];
      addrs = '{`FMT_FLAG_ADDR, `LNK_FLAG_ADDR, `RCV_FLAG_ADDR, `FMT_BASE_ADDR,
                `LNK_BASE_ADDR, `RCV_BASE_ADDR, 8'h7F};
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      wr(8'h7F, 8'hFF);
      foreach (addrs[i]) begin
         rd(addrs[i], v);
         check(v, `REG_RESET);
      end
      run_group(GRP_FMT, `FMT_FLAG_ADDR, `FMT_BASE_ADDR, 4, 1'b0);
      run_group(GRP_LNK, `LNK_FLAG_ADDR, `LNK_BASE_ADDR, 2, 1'b0);
      run_group(GRP_RCV, `RCV_FLAG_ADDR, `RCV_BASE_ADDR, 2, 1'b1);
      conclude();
   end
endmodule : test_remote_register_update_ctrl
